// *** include/acr_defs.svh ***
// constants of the chip-select readout block: timing, word layout, frame lengths
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH

// system clock period and conversion time
`define ACR_CLK_PERIOD_NS 5
`define ACR_T_CONV_NS 700
// conversion time in system cycles, rounded up
`define ACR_CONV_CYC ((`ACR_T_CONV_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)

// result and shift word layout, counter and timer widths
`define ACR_RES_W 18
`define ACR_WORD_W 19
`define ACR_WORD_MSB 18
`define ACR_CNT_W 5
`define ACR_TMR_W 8

// falling sclk edges until the output floats, and the ceiling of the edge count
`define ACR_FRAME_PLAIN 5'h12
`define ACR_FRAME_BUSY 5'h13
`define ACR_CNT_MAX 5'h1F

`endif

// *** include/acr_pkg.sv ***
// types shared by the chip-select readout block
package acr_pkg;
    `include "acr_defs.svh"

    // one-hot states of the system-domain sequencer
    typedef enum logic [3:0] {
        ACR_IDLE = 4'h1,
        ACR_CONV = 4'h2,
        ACR_ACQ = 4'h4,
        ACR_READ = 4'h8
    } acr_state_e;

    // the two host pins after synchronisation
    typedef struct packed {
        logic trig;
        logic din;
    } acr_pins_s;

    // serial output pin as output and active-low enable
    typedef struct packed {
        logic dout;
        logic oe_n;
    } acr_pin_out_s;

    // whole state of the system-domain sequencer
    typedef struct packed {
        acr_state_e state;
        acr_pins_s pins_q;
        logic [`ACR_TMR_W-1:0] tmr;
        logic [`ACR_WORD_W-1:0] word;
        logic [`ACR_CNT_W-1:0] limit;
        logic frame;
        logic daisy;
        logic sample;
        logic power;
        acr_pin_out_s pin;
    } acr_seq_s;

    // state of the link-domain edge counter
    typedef struct packed {
        logic [`ACR_CNT_W-1:0] bin;
        logic [`ACR_CNT_W-1:0] gray;
    } acr_link_s;
endpackage

// *** verification/acr_checker.sv ***
// pin-level assertions for the chip-select readout block
`include "acr_defs.svh"
module acr_checker
    import acr_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // reset, active low
    input wire logic conversion_trigger, // trigger pin
    input wire logic serial_data_in, // data-in pin
    input wire logic sclk, // serial clock
    input wire logic [`ACR_RES_W-1:0] sar_result, // array result
    input wire logic serial_result_out, // output level
    input wire logic serial_result_oe_n, // output enable, active low
    input wire logic sample_pulse, // sample strobe
    input wire logic converter_power, // converter powered
    input wire logic daisy_selected // daisy flag
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [7:0] pwr_cnt_reg;
    // cycles the converter has been powered so far
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            pwr_cnt_reg <= 8'h00;
        else
            pwr_cnt_reg <= converter_power ? pwr_cnt_reg + 8'h01 : 8'h00;
    end
    // trigger rise outside a conversion, and the end of a conversion
    sequence s_rise_idle;
        $rose(conversion_trigger) && !converter_power;
    endsequence
    sequence s_conv_end;
        $fell(converter_power);
    endsequence
    property p_cs_start;
        s_rise_idle ##0 serial_data_in |-> ##[1:5] (sample_pulse && serial_result_oe_n);
    endproperty
    property p_daisy;
        s_rise_idle ##0 !serial_data_in |-> ##[1:5] daisy_selected;
    endproperty
    property p_pulse;
        sample_pulse |=> !sample_pulse;
    endproperty
    property p_power_rise;
        $rose(converter_power) |-> sample_pulse;
    endproperty
    property p_conv_time;
        s_conv_end |-> pwr_cnt_reg == 8'h8C;
    endproperty
    property p_float_conv;
        converter_power |-> serial_result_oe_n;
    endproperty
    property p_plain_end;
        s_conv_end ##0 (conversion_trigger && serial_data_in) |-> serial_result_oe_n;
    endproperty
    property p_busy_end;
        s_conv_end ##0 !(conversion_trigger && serial_data_in)
            |-> !serial_result_oe_n && !serial_result_out;
    endproperty
    property p_trig_float;
        s_rise_idle |-> ##[1:5] serial_result_oe_n;
    endproperty
    property p_din_float;
        $rose(serial_data_in) && !converter_power |-> ##[1:5] serial_result_oe_n;
    endproperty
    property p_open_plain;
        $fell(serial_data_in) && conversion_trigger && !converter_power
            |-> ##[1:5] !serial_result_oe_n;
    endproperty
    a_cs_start: assert property (p_cs_start) else $error("no conversion start");
    a_daisy: assert property (p_daisy) else $error("daisy not flagged");
    a_pulse: assert property (p_pulse) else $error("sample pulse too long");
    a_power_rise: assert property (p_power_rise) else $error("power without sample");
    a_conv_time: assert property (p_conv_time) else $error("conversion length");
    a_float_conv: assert property (p_float_conv) else $error("driven in conversion");
    a_plain_end: assert property (p_plain_end) else $error("busy bit not omitted");
    a_busy_end: assert property (p_busy_end) else $error("busy bit missing");
    a_trig_float: assert property (p_trig_float) else $error("no float on trigger");
    a_din_float: assert property (p_din_float) else $error("no float on data-in");
    a_open_plain: assert property (p_open_plain) else $error("frame not opened");
endmodule

bind acr_top acr_checker u_chk (.clk_sys, .arst_n, .conversion_trigger, .serial_data_in,
    .sclk, .sar_result, .serial_result_out, .serial_result_oe_n, .sample_pulse,
    .converter_power, .daisy_selected);

// *** verification/acr_host_model.sv ***
// host model: trigger, chip select and serial clock, captures the result
module acr_host_model (
    input wire logic clk_sys, // pacing clock
    input wire logic line, // data line with pull-up
    output logic trig, // conversion trigger
    output logic din, // data-in, chip select in four-wire use
    output logic sclk // serial clock, still between frames
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle pins at time zero
    initial begin
        trig = 1'b0;
        din = 1'b1;
        sclk = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // start, hold the pins across the window, open the frame, read n bits
    task automatic xfer(input logic w4, input logic busy, input int n, output logic [18:0] w);
        w = 19'h0_0000;
        din = 1'b1;
        trig = 1'b0;
        wt(4);
        trig = 1'b1;
        wt(10);
        if (!w4 && !busy) begin
            trig = 1'b0;
            wt(5);
            trig = 1'b1;
        end
        if (w4)
            din = !busy;
        else
            trig = !busy;
        wt(150);
        if (!busy) begin
            if (w4)
                din = 1'b0;
            else
                trig = 1'b0;
            wt(6);
        end
        for (int i = 0; i < n; i++) begin
            #15 sclk = 1'b1;
            #14 w = {w[17:0], line};
            #1 sclk = 1'b0;
        end
        wt(1);
    endtask
    // end the frame by chip select
    task automatic release_cs(input logic w4);
        if (w4)
            din = 1'b1;
        else
            trig = 1'b1;
    endtask
    // daisy-chain selection: trigger rise with data-in low
    task automatic daisy();
        trig = 1'b0;
        wt(4);
        din = 1'b0;
        wt(4);
        trig = 1'b1;
        wt(8);
    endtask
endmodule

// *** verification/tb_adc_chip_select_serial_readout.sv ***
// self-checking bench of the chip-select readout block
`include "acr_defs.svh"
module tb_adc_chip_select_serial_readout
    import acr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, arst_n, trig, din, sclk, dout, oe_n, pulse, power, daisy_f, line;
    logic w4, busy;
    logic [`ACR_RES_W-1:0] sar_result;
    logic [17:0] exp;
    logic [18:0] word;
    int nb, err_total, n_compared;
    // pull-up on the shared output line
    assign line = oe_n ? 1'b1 : dout;
    acr_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .conversion_trigger(trig),
        .serial_data_in(din), .sclk(sclk), .sar_result(sar_result),
        .serial_result_out(dout), .serial_result_oe_n(oe_n), .sample_pulse(pulse),
        .converter_power(power), .daisy_selected(daisy_f));
    acr_host_model host (.clk_sys(clk_sys), .line(line), .trig(trig), .din(din),
        .sclk(sclk));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [18:0] seen, input logic [18:0] ex);
        n_compared++;
        if (seen !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    // bounded wait for the output to float
    task automatic wait_oe(input int lim);
        int i;
        i = 0;
        while (oe_n !== 1'b1 && i < lim) begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        check("oe_n float", oe_n, 19'h0_0001);
        if (oe_n !== 1'b1)
            final_report();
    endtask
    // four modes read whole, then two aborted frames, then daisy selection
    initial begin
        err_total = 0;
        n_compared = 0;
        arst_n = 1'b0;
        sar_result = 18'h0_0000;
        void'($urandom(32'hb3c6));
        repeat (2) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        host.wt(4);
        for (int m = 0; m < 6; m++) begin
            w4 = m[2] ? m[0] : m[1];
            busy = m[0] & ~m[2];
            nb = m[2] ? 5 : 18 + busy;
            sar_result = 18'($urandom);
            exp = 18'(int'(sar_result) - 131072);
            host.xfer(w4, busy, nb, word);
            check("power", power, 19'h0_0000);
            if (nb == 5) begin
                check("part", word, {14'h0000, exp[17:13]});
                check("oe_n open", oe_n, 19'h0_0000);
                host.release_cs(w4);
                wait_oe(8);
            end else begin
                check("word", word, {1'b0, exp});
                wait_oe(8);
                host.release_cs(w4);
            end
            host.wt(w4 ? 6 : 160);
        end
        host.daisy();
        check("daisy", daisy_f, 19'h0_0001);
        check("daisy oe_n", oe_n, 19'h0_0001);
        check("daisy power", power, 19'h0_0000);
        final_report();
    end
endmodule

// *** verilog/acr_link_count.sv ***
// counts falling sclk edges of a readout frame, gray coded for the crossing
`include "acr_defs.svh"
module acr_link_count
    import acr_pkg::*;
(
    input wire logic sclk, // serial clock from the host, still between frames
    input wire logic frame_n, // low outside a frame: holds the count at zero
    output logic [`ACR_CNT_W-1:0] cnt_gray // gray coded edge count
);
    acr_link_s st_reg;
    acr_link_s st_next;
    logic [`ACR_CNT_W-1:0] bin_inc;

    // saturating count so a long burst cannot wrap back to a live bit
    always_comb begin
        st_next = st_reg;
        bin_inc = st_reg.bin + 5'h01;
        if (st_reg.bin != `ACR_CNT_MAX) begin
            st_next.bin = bin_inc;
        end
        st_next.gray = st_next.bin ^ (st_next.bin >> 1);
    end

    // frame_n comes from a register, so it clears without glitches
    always_ff @(negedge sclk or negedge frame_n) begin
        if (!frame_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cnt_gray = st_reg.gray;
endmodule

// *** verilog/acr_sync.sv ***
// two flip-flop synchroniser into the system clock domain
module acr_sync
    import acr_pkg::*;
#(
    parameter int W = 2
) (
    input wire logic clk_sys, // system clock
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic [W-1:0] d_in, // signal from another domain
    output logic [W-1:0] d_out // synchronised copy
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } acr_sync_s;

    acr_sync_s st_reg;
    acr_sync_s st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d_in;
        st_next.s2 = st_reg.s1;
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign d_out = st_reg.s2;
endmodule

// *** verilog/acr_top.sv ***
// chip-select mode conversion control and serial readout of a SAR converter
//
// How it works
// - trigger rising with data-in high selects chip-select mode.
// - trigger rising with data-in low selects daisy-chain mode instead.
// - trigger rise floats the output; with data-in high it also samples the input, starts conversion.
// - conversion runs on internal timing, ignoring the trigger pin meanwhile.
// - three-wire: trigger high at conversion end means no busy bit.
// - conversion end powers the converter down; plain modes then enter acquisition.
// - three-wire plain: trigger falling shows MSB; sclk falls shift lower bits.
// - three-wire plain: output floats after 18th fall or trigger rise.
// - three-wire: trigger low at conversion end makes a busy bit.
// - busy mode: conversion end drives low busy bit, then MSB-first shifting.
// - three-wire busy: output floats after 19th fall or trigger rise.
// - four-wire: data-in high at conversion end omits the busy bit.
// - four-wire plain: data-in falling shows MSB; sclk falls shift lower bits.
// - four-wire plain: output floats after 18th fall or data-in rise.
// - shared line: next chip select falls only after previous output floats.
// - four-wire busy: data-in low at conversion end makes a busy bit.
// - four-wire busy: output floats after 19th fall or data-in rise.
// - result leaves in two's complement over twice the reference span.
`include "acr_defs.svh"
module acr_top
    import acr_pkg::*;
(
    input wire logic clk_sys, // system clock, 200 MHz
    input wire logic arst_n, // asynchronous reset, active low
    input wire logic conversion_trigger, // trigger pin from the host
    input wire logic serial_data_in, // data-in pin, chip select in four-wire use
    input wire logic sclk, // serial clock pin from the host
    input wire logic [`ACR_RES_W-1:0] sar_result, // offset binary result of the array
    output logic serial_result_out, // serial output pin level
    output logic serial_result_oe_n, // serial output enable, low while driving
    output logic sample_pulse, // one-cycle pulse: array samples the input
    output logic converter_power, // high while the converter is powered
    output logic daisy_selected // high after a daisy-chain selection
);
    acr_seq_s st_reg;
    acr_seq_s st_next;
    acr_pins_s pins_s;
    logic [`ACR_CNT_W-1:0] cnt_gray_s;
    logic [`ACR_CNT_W-1:0] cnt_bin_gray;
    logic [`ACR_CNT_W-1:0] cnt_bin;
    logic [`ACR_CNT_W-1:0] bit_idx;
    logic trig_rise;
    logic trig_fall;
    logic din_rise;
    logic din_fall;
    logic busy_sel;
    logic frame_n;

    // both host pins cross into the system domain before any decision
    acr_sync #(
        .W(2)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d_in({conversion_trigger, serial_data_in}),
        .d_out(pins_s)
    );

    // link-domain counter of falling sclk edges, cleared outside a frame
    assign frame_n = st_reg.frame;

    acr_link_count u_link (
        .sclk(sclk),
        .frame_n(frame_n),
        .cnt_gray(cnt_gray_s)
    );

    // gray count crosses back as a word, one bit changing per edge
    acr_sync #(
        .W(`ACR_CNT_W)
    ) u_cnt_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .d_in(cnt_gray_s),
        .d_out(cnt_bin_gray)
    );

    // gray to binary conversion of the synchronised count
    genvar gi;
    generate
        for (gi = 0; gi < `ACR_CNT_W; gi++) begin : g_gray
            assign cnt_bin[gi] = ^cnt_bin_gray[`ACR_CNT_W-1:gi];
        end
    endgenerate

    // edges of the synchronised pins
    assign trig_rise = pins_s.trig & ~st_reg.pins_q.trig;
    assign trig_fall = ~pins_s.trig & st_reg.pins_q.trig;
    assign din_rise = pins_s.din & ~st_reg.pins_q.din;
    assign din_fall = ~pins_s.din & st_reg.pins_q.din;

    // busy bit wanted unless both pins stand high at conversion end
    assign busy_sel = ~(pins_s.trig & pins_s.din);

    // bit position shown for the current edge count
    assign bit_idx = 5'(`ACR_WORD_MSB) - cnt_bin;

    // sequencer: conversion timing, busy choice, frame open and close
    always_comb begin
        st_next = st_reg;
        st_next.pins_q = pins_s;
        st_next.sample = 1'b0;
        case (st_reg.state)
            ACR_IDLE, ACR_ACQ, ACR_READ: begin
                if (trig_rise) begin
                    // a new trigger always floats the output first
                    st_next.pin.oe_n = 1'b1;
                    st_next.pin.dout = 1'b0;
                    st_next.frame = 1'b0;
                    if (pins_s.din) begin
                        st_next.daisy = 1'b0;
                        st_next.state = ACR_CONV;
                        st_next.sample = 1'b1;
                        st_next.power = 1'b1;
                        st_next.tmr = `ACR_TMR_W'(`ACR_CONV_CYC);
                    end else begin
                        // daisy chain lies outside this block: stay quiet
                        st_next.daisy = 1'b1;
                        st_next.state = ACR_IDLE;
                    end
                end else if (st_reg.state == ACR_ACQ) begin
                    if (trig_fall || din_fall) begin
                        // plain modes: chip select falling shows the MSB
                        st_next.frame = 1'b1;
                        st_next.pin.oe_n = 1'b0;
                        st_next.pin.dout = st_reg.word[`ACR_WORD_MSB];
                        st_next.state = ACR_READ;
                    end
                end else if (st_reg.state == ACR_READ) begin
                    if (din_rise) begin
                        // chip select rising ends the frame early
                        st_next.pin.oe_n = 1'b1;
                        st_next.frame = 1'b0;
                        st_next.state = ACR_IDLE;
                    end else if (cnt_bin >= st_reg.limit) begin
                        // last bit shown: output floats after the final fall
                        st_next.pin.oe_n = 1'b1;
                        st_next.frame = 1'b0;
                        st_next.state = ACR_IDLE;
                    end else begin
                        // each falling sclk edge presents the next lower bit
                        st_next.pin.dout = st_reg.word[bit_idx];
                    end
                end
            end
            ACR_CONV: begin
                // internal timing only: pin activity cannot stop it
                st_next.tmr = st_reg.tmr - `ACR_TMR_W'(1);
                if (st_reg.tmr == `ACR_TMR_W'(1)) begin
                    st_next.power = 1'b0;
                    if (busy_sel) begin
                        // busy layout: low flag bit ahead of the result
                        st_next.word = {1'b0, ~sar_result[`ACR_RES_W-1],
                            sar_result[`ACR_RES_W-2:0]};
                        st_next.limit = `ACR_FRAME_BUSY;
                        st_next.frame = 1'b1;
                        st_next.pin.oe_n = 1'b0;
                        st_next.pin.dout = 1'b0;
                        st_next.state = ACR_READ;
                    end else begin
                        // plain layout: MSB first, a spare bit at the end
                        st_next.word = {~sar_result[`ACR_RES_W-1],
                            sar_result[`ACR_RES_W-2:0], 1'b0};
                        st_next.limit = `ACR_FRAME_PLAIN;
                        st_next.state = ACR_ACQ;
                    end
                end
            end
            default: begin
                st_next.state = ACR_IDLE;
                st_next.frame = 1'b0;
                st_next.pin.oe_n = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.state <= ACR_IDLE;
            st_reg.pins_q <= '0;
            st_reg.tmr <= '0;
            st_reg.word <= '0;
            st_reg.limit <= `ACR_FRAME_PLAIN;
            st_reg.frame <= 1'b0;
            st_reg.daisy <= 1'b0;
            st_reg.sample <= 1'b0;
            st_reg.power <= 1'b0;
            st_reg.pin.dout <= 1'b0;
            st_reg.pin.oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state register
    assign serial_result_out = st_reg.pin.dout;
    assign serial_result_oe_n = st_reg.pin.oe_n;
    assign sample_pulse = st_reg.sample;
    assign converter_power = st_reg.power;
    assign daisy_selected = st_reg.daisy;
endmodule
